// ==== verilog/cmc_mode_ctrl.sv ====
// Mode control of a CAN controller: control register zero, the
// init and sleep handshakes, bus sync, time stamp and config gating.
// Assumes a protocol engine on the same clock feeds cmc_eng_type.
`timescale 1ns/10ps

module cmc_mode_ctrl import cmc_pkg::*; (
	// Clock and reset
	input  wire logic          clk,
	input  wire logic          nrst,
	// Register port
	input  wire logic [7:0]    reg_addr,
	input  wire logic [7:0]    reg_wdata,
	input  wire logic          reg_wr,
	input  wire logic          reg_rd,
	output logic [7:0]         reg_rdata,
	// Bus pins
	input  wire logic          bus_rx_pin,
	output logic               bus_tx_pin,
	// Protocol engine
	input  wire cmc_eng_type   eng,
	output logic               eng_abort,
	output logic               eng_synced,
	output logic               eng_sleep,
	output logic               mode_loopback,
	output logic               mode_listen,
	// Message buffer time stamp
	output cmc_stamp_type      stamp,
	// System
	input  wire logic          cpu_wait,
	output logic               bus_clk_en
);

	//------------------------------------------------------------
	// Declarations
	//------------------------------------------------------------
	cmc_main_type s_r;      // Registered state
	cmc_main_type s_nxt;    // Next state
	logic         rx_lvl;   // Clean receive level
	logic         in_init;  // Init mode fully entered
	logic         out_init; // Init mode fully left
	logic         wr_filt;  // Write hits filter bytes
	logic         rd_alt;   // Read served by register mux
	logic [7:0]   rd_mux;   // Register read value
	logic [7:0]   wd;       // Write data shorthand

	assign wd       = reg_wdata;
	assign in_init  = s_r.init_request & s_r.init_ack;
	assign out_init = ~s_r.init_request & ~s_r.init_ack;

	//------------------------------------------------------------
	// Receive pin synchroniser
	//------------------------------------------------------------
	cmc_rx_sync u_rx_sync (
		.clk   (clk),
		.nrst  (nrst),
		.pin   (bus_rx_pin),
		.level (rx_lvl)
	);

	//------------------------------------------------------------
	// Register read mux
	//------------------------------------------------------------
	// Loopback leaves frame and active flags without meaning
	always_comb begin
		rd_mux = 8'h00;
		unique case (reg_addr)
			OFF_CTL0:  rd_mux = {s_r.received_frame_flag, eng.rx_busy, s_r.stop_in_wait, s_r.synced,
				s_r.time_en, s_r.wake_enable, s_r.sleep_request, s_r.init_request};
			OFF_CTL1:  rd_mux = {s_r.ctl1_cfg[7:2], s_r.sleep_ack, s_r.init_ack};
			OFF_BT0:   rd_mux = s_r.bt0;
			OFF_BT1:   rd_mux = s_r.bt1;
			OFF_RFLG:  rd_mux = {s_r.wake_irq_flag, 1'b0, eng.err_state, 2'b00};
			OFF_RIER:  rd_mux = s_r.rier;
			OFF_TFLG:  rd_mux = {5'h00, s_r.tflg};
			OFF_TIER:  rd_mux = {5'h00, s_r.tier};
			OFF_TARQ:  rd_mux = {5'h00, s_r.tarq};
			OFF_TBSEL: rd_mux = {5'h00, s_r.tbsel};
			OFF_IDAC:  rd_mux = {2'b00, s_r.idam, 4'h0};
			default:   rd_mux = 8'h00; // Unmapped and abort ack read zero
		endcase
	end

	assign rd_alt  = (reg_addr[7:4] != OFF_FILT_HI);
	// Filter values are configuration: only taken in init mode
	assign wr_filt = reg_wr & ~rd_alt & in_init;

	//------------------------------------------------------------
	// Filter store and read data register
	//------------------------------------------------------------
	cmc_rd_store u_rd_store (
		.clk      (clk),
		.nrst     (nrst),
		.wr_en    (wr_filt),
		.wr_idx   (reg_addr[3:0]),
		.wr_data  (reg_wdata),
		.rd_en    (reg_rd),
		.rd_idx   (reg_addr[3:0]),
		.use_alt  (rd_alt),
		.alt_data (rd_mux),
		.rd_q     (reg_rdata)
	);

	//------------------------------------------------------------
	// Next state
	//------------------------------------------------------------
	always_comb begin
		s_nxt          = s_r;
		s_nxt.abort    = 1'b0;
		s_nxt.stamp.we = 1'b0;

		// Control zero writes
		if (reg_wr && reg_addr == OFF_CTL0) begin
			// Plain bits only once init is fully left
			if (out_init) begin
				if (wd[BIT_FRAME]) begin
					s_nxt.received_frame_flag = 1'b0;
				end
				s_nxt.stop_in_wait   = wd[BIT_STOP_WAIT];
				s_nxt.time_en = wd[BIT_TIMER];
			end
			// Active and synced bits are never stored from a write
			s_nxt.wake_enable = wd[BIT_WAKE_EN];
			if (wd[BIT_SLEEP_RQ]) begin
				// Wake flag pending blocks a new sleep request
				if (!s_r.wake_irq_flag) begin
					s_nxt.sleep_request = 1'b1;
				end
			end else if (s_r.sleep_ack || !s_r.sleep_request) begin
				s_nxt.sleep_request = 1'b0;
			end
			if (wd[BIT_INIT_RQ]) begin
				s_nxt.init_request = 1'b1;
			end else if (s_r.init_ack) begin
				s_nxt.init_request = 1'b0;
			end
		end

		// Config writes, init mode only
		if (reg_wr && in_init) begin
			unique case (reg_addr)
				OFF_CTL1: s_nxt.ctl1_cfg = {wd[7:2], 2'b00};
				OFF_BT0:  s_nxt.bt0 = wd;
				OFF_BT1:  s_nxt.bt1 = wd;
				OFF_IDAC: s_nxt.idam = wd[5:4];
				default: ;
			endcase
		end

		// Flag and buffer registers
		if (reg_wr) begin
			unique case (reg_addr)
				OFF_RFLG: begin
					if (wd[BIT_WAKE_FLAG]) begin
						s_nxt.wake_irq_flag = 1'b0;
					end
				end
				OFF_RIER:  s_nxt.rier = wd;
				OFF_TFLG:  s_nxt.tflg = s_r.tflg & ~wd[2:0];
				OFF_TIER:  s_nxt.tier = wd[2:0];
				OFF_TARQ:  s_nxt.tarq = wd[2:0];
				OFF_TBSEL: s_nxt.tbsel = wd[2:0];
				default: ;
			endcase
		end
		// Engine sets win over software clears
		s_nxt.tflg = s_nxt.tflg | eng.tx_done;
		if (eng.rx_frame_ok) begin
			s_nxt.received_frame_flag = 1'b1;
		end

		// Time-stamp timer, bit rate
		if (!s_r.time_en) begin
			s_nxt.tmr = 16'h0000;
		end else if (eng.bit_tick) begin
			s_nxt.tmr = s_r.tmr + 16'h0001;
		end

		// Stamp: high byte then low byte on the next cycle
		if (eng.eof_ok && s_r.time_en) begin
			s_nxt.stamp   = '{we: 1'b1, off: STAMP_HI, data: s_r.tmr[15:8]};
			s_nxt.ts_lo   = s_r.tmr[7:0];
			s_nxt.ts_pend = 1'b1;
		end else if (s_r.ts_pend) begin
			s_nxt.stamp   = '{we: 1'b1, off: STAMP_LO, data: s_r.ts_lo};
			s_nxt.ts_pend = 1'b0;
		end

		// Mode sequence
		unique case (s_r.st)
			ST_INIT: begin
				// Left only by the init exit below
			end
			ST_WAIT: begin
				// Count recessive bits until the bus is seen idle
				if (eng.bit_tick) begin
					if (!rx_lvl) begin
						s_nxt.rcnt = 4'h0;
					end else if (s_r.rcnt == CNT_IDLE - 4'h1) begin
						s_nxt.rcnt = 4'h0;
						if (eng.bus_off && s_r.bocnt != CNT_BUSOFF - 8'h01) begin
							s_nxt.bocnt = s_r.bocnt + 8'h01;
						end else begin
							s_nxt.st = ST_RUN;
						end
					end else begin
						s_nxt.rcnt = s_r.rcnt + 4'h1;
					end
				end
			end
			ST_RUN: begin
				// Sleep only with no reception and all buffers empty
				if (s_r.sleep_request && !eng.rx_busy && s_r.tflg == RST_TFLG) begin
					s_nxt.st    = ST_SLEEP;
					s_nxt.sleep_ack = 1'b1;
				end
			end
			ST_SLEEP: begin
				if (!s_r.sleep_request) begin
					// Resync before taking part again
					s_nxt.st    = ST_WAIT;
					s_nxt.sleep_ack = 1'b0;
					s_nxt.rcnt  = 4'h0;
					s_nxt.bocnt = 8'h00;
				end else if (s_r.wake_enable && !rx_lvl) begin
					// Dominant level counts as traffic
					s_nxt.sleep_request = 1'b0;
					s_nxt.wake_irq_flag = 1'b1;
				end
			end
		endcase

		// Init entry: abort, drop sync, restore defaults
		if (s_r.init_request && !s_r.init_ack) begin
			s_nxt.init_ack  = 1'b1;
			s_nxt.abort   = 1'b1;
			s_nxt.st      = ST_INIT;
			s_nxt.sleep_ack   = 1'b0;
			s_nxt.received_frame_flag   = 1'b0;
			s_nxt.wake_irq_flag   = 1'b0;
			s_nxt.rier    = s_r.rier & RIER_KEEP;
			s_nxt.tflg    = RST_TFLG;
			s_nxt.tier    = 3'h0;
			s_nxt.tarq    = 3'h0;
			s_nxt.tbsel   = 3'h0;
			s_nxt.ts_pend = 1'b0;
			// Error counters live in the engine and are not touched
		end

		// Init exit: acknowledge drops, then resync
		if (!s_r.init_request && s_r.init_ack) begin
			s_nxt.init_ack = 1'b0;
			s_nxt.st     = ST_WAIT;
			s_nxt.rcnt   = 4'h0;
			s_nxt.bocnt  = 8'h00;
		end

		// Held at reset values while in init mode
		if (in_init) begin
			s_nxt.received_frame_flag   = 1'b0;
			s_nxt.stop_in_wait   = 1'b0;
			s_nxt.time_en = 1'b0;
		end

		// Clock gate in wait mode when stop-in-wait is set
		s_nxt.clk_en = ~(cpu_wait & s_nxt.stop_in_wait);

		// Transmit pin: recessive unless running on the bus
		if (s_nxt.st == ST_RUN && !s_nxt.init_request && s_nxt.clk_en &&
			!s_nxt.ctl1_cfg[BIT_LOOP] && !s_nxt.ctl1_cfg[BIT_LISTEN]) begin
			s_nxt.txd = eng.tx_bit;
		end else begin
			s_nxt.txd = 1'b1;
		end

		// Synced only while running
		s_nxt.synced = (s_nxt.st == ST_RUN);
	end

	//------------------------------------------------------------
	// State register
	//------------------------------------------------------------
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			s_r <= MAIN_RST;
		end else begin
			s_r <= s_nxt;
		end
	end

	//------------------------------------------------------------
	// Outputs, all from flops
	//------------------------------------------------------------
	assign bus_tx_pin    = s_r.txd;
	assign bus_clk_en    = s_r.clk_en;
	assign eng_abort     = s_r.abort;
	assign eng_synced    = s_r.synced;
	assign eng_sleep     = s_r.sleep_ack;
	assign mode_loopback = s_r.ctl1_cfg[BIT_LOOP];
	assign mode_listen   = s_r.ctl1_cfg[BIT_LISTEN];
	assign stamp         = s_r.stamp;

endmodule : cmc_mode_ctrl

// ==== verilog/cmc_pkg.sv ====
// Constants, carriers and state types for the CAN mode control block.
// Assumes one 10 MHz clock, reset nrst, and a protocol engine on the same clock.
//
// Overview of operation
// - Init mode holds control zero at reset, except the wake enable, sleep and init request bits.
// - Control zero writable once init fully left.
// - Good frame sets flag; write one clears.
// - Receiver active flag follows the receiver.
// - Stop-in-wait gates bus clocks in wait.
// - Only hardware sets and clears synced flag.
// - Timer enable runs 16-bit bit-rate counter.
// - Stamp written at offsets 0x0E, 0x0F after EOF.
// - Timer cleared when off; enable low in init.
// - Wake enable lets bus traffic end sleep.
// - Sleep taken only when bus is idle.
// - Sleep request refused while wake flag set.
// - Sleep ends by CPU or bus activity.
// - Init request aborts traffic, drops sync, acknowledges.
// - Init entry restores listed registers to defaults.
// - Config registers written only in init mode.
// - Error counters untouched by init mode.
// - Resync after 11 recessive bits, bus-off 128.
// - Frame and active flags meaningless in loopback.
// - Transmit pin low dominant, high recessive.
// - Init request not clearable before acknowledge.
// - Init request forces transmit pin recessive.

package cmc_pkg;

	//------------------------------------------------------------
	// Register offsets
	//------------------------------------------------------------
	localparam logic [7:0] OFF_CTL0  = 8'h00;
	localparam logic [7:0] OFF_CTL1  = 8'h01;
	localparam logic [7:0] OFF_BT0   = 8'h02;
	localparam logic [7:0] OFF_BT1   = 8'h03;
	localparam logic [7:0] OFF_RFLG  = 8'h04;
	localparam logic [7:0] OFF_RIER  = 8'h05;
	localparam logic [7:0] OFF_TFLG  = 8'h06;
	localparam logic [7:0] OFF_TIER  = 8'h07;
	localparam logic [7:0] OFF_TARQ  = 8'h08;
	localparam logic [7:0] OFF_TAAK  = 8'h09;
	localparam logic [7:0] OFF_TBSEL = 8'h0A;
	localparam logic [7:0] OFF_IDAC  = 8'h0B;
	localparam logic [3:0] OFF_FILT_HI = 4'h1; // Filter bytes at 0x10..0x1F

	//------------------------------------------------------------
	// Bit positions
	//------------------------------------------------------------
	localparam int BIT_FRAME     = 7;
	localparam int BIT_STOP_WAIT = 5;
	localparam int BIT_TIMER     = 3;
	localparam int BIT_WAKE_EN   = 2;
	localparam int BIT_SLEEP_RQ  = 1;
	localparam int BIT_INIT_RQ   = 0;
	localparam int BIT_ENABLE    = 7;
	localparam int BIT_CLK_SRC   = 6;
	localparam int BIT_LOOP      = 5;
	localparam int BIT_LISTEN    = 4;
	localparam int BIT_BO_MODE   = 3;
	localparam int BIT_WAKE_MODE = 2;
	localparam int BIT_WAKE_FLAG = 7;

	//------------------------------------------------------------
	// Reset values and counts
	//------------------------------------------------------------
	localparam logic [2:0] RST_TFLG    = 3'h7;
	localparam logic [7:0] RIER_KEEP   = 8'h3C; // Status enables survive init
	localparam logic [3:0] CNT_IDLE    = 4'hB;  // 11 recessive bits
	localparam logic [7:0] CNT_BUSOFF  = 8'h80; // 128 idle sequences
	localparam logic [3:0] STAMP_HI    = 4'hE;
	localparam logic [3:0] STAMP_LO    = 4'hF;

	//------------------------------------------------------------
	// Types
	//------------------------------------------------------------
	typedef enum logic [1:0] {
		ST_INIT  = 2'b00,
		ST_WAIT  = 2'b01,
		ST_RUN   = 2'b11,
		ST_SLEEP = 2'b10
	} cmc_state_type;

	// Inputs from the protocol engine
	typedef struct packed {
		logic       tx_bit;
		logic       rx_busy;
		logic       rx_frame_ok;
		logic       eof_ok;
		logic       bit_tick;
		logic       bus_off;
		logic [2:0] tx_done;
		logic [3:0] err_state;
	} cmc_eng_type;

	// Time-stamp byte write toward the message buffer
	typedef struct packed {
		logic       we;
		logic [3:0] off;
		logic [7:0] data;
	} cmc_stamp_type;

	// Whole state of the main module
	typedef struct packed {
		cmc_state_type st;
		logic          received_frame_flag;
		logic          stop_in_wait;
		logic          time_en;
		logic          wake_enable;
		logic          sleep_request;
		logic          init_request;
		logic          sleep_ack;
		logic          init_ack;
		logic [7:0]    ctl1_cfg;
		logic [7:0]    bt0;
		logic [7:0]    bt1;
		logic          wake_irq_flag;
		logic [7:0]    rier;
		logic [2:0]    tflg;
		logic [2:0]    tier;
		logic [2:0]    tarq;
		logic [2:0]    tbsel;
		logic [1:0]    idam;
		logic [3:0]    rcnt;
		logic [7:0]    bocnt;
		logic [15:0]   tmr;
		logic          ts_pend;
		logic [7:0]    ts_lo;
		cmc_stamp_type stamp;
		logic          txd;
		logic          clk_en;
		logic          abort;
		logic          synced;
	} cmc_main_type;

	// Out of reset the block sits in init mode, listen bit set
	localparam cmc_main_type MAIN_RST = '{
		st: ST_INIT, init_request: 1'b1, init_ack: 1'b1,
		ctl1_cfg: 8'h10, tflg: RST_TFLG, txd: 1'b1, clk_en: 1'b1,
		default: '0
	};

endpackage : cmc_pkg

// ==== verilog/cmc_rx_sync.sv ====
// Three-stage synchroniser for the bus receive pin.
// Assumes the pin is asynchronous to clk; idles recessive (high).
`timescale 1ns/10ps

module cmc_rx_sync import cmc_pkg::*; (
	// Clock and reset
	input  wire logic clk,
	input  wire logic nrst,
	// Pin and clean level
	input  wire logic pin,
	output logic      level
);

	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
		logic lvl;
	} cmc_sync_type;

	cmc_sync_type s_r;   // Registered state
	cmc_sync_type s_nxt; // Next state

	//------------------------------------------------------------
	// Shift and agree
	//------------------------------------------------------------
	// Only s2 reads s1; level moves when s2 and s3 agree
	always_comb begin
		s_nxt    = s_r;
		s_nxt.s1 = pin;
		s_nxt.s2 = s_r.s1;
		s_nxt.s3 = s_r.s2;
		if (s_r.s2 == s_r.s3) begin
			s_nxt.lvl = s_r.s3;
		end
	end

	// Recessive at reset so nothing looks like traffic
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			s_r <= '1;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign level = s_r.lvl;

endmodule : cmc_rx_sync

// ==== verilog/cmc_rd_store.sv ====
// Filter byte store plus the read data register of the block.
// Assumes write and read strobes are one cycle long.
`timescale 1ns/10ps

module cmc_rd_store import cmc_pkg::*; (
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       nrst,
	// Write side
	input  wire logic       wr_en,
	input  wire logic [3:0] wr_idx,
	input  wire logic [7:0] wr_data,
	// Read side
	input  wire logic       rd_en,
	input  wire logic [3:0] rd_idx,
	input  wire logic       use_alt,
	input  wire logic [7:0] alt_data,
	output logic [7:0]      rd_q
);

	typedef struct packed {
		logic [15:0][7:0] mem;
		logic [7:0]       q;
	} cmc_store_type;

	cmc_store_type s_r;   // Registered state
	cmc_store_type s_nxt; // Next state

	//------------------------------------------------------------
	// Store and read register
	//------------------------------------------------------------
	// Read data only valid the cycle after the strobe; zero otherwise
	always_comb begin
		s_nxt   = s_r;
		s_nxt.q = 8'h00;
		if (wr_en) begin
			s_nxt.mem[wr_idx] = wr_data;
		end
		if (rd_en) begin
			s_nxt.q = use_alt ? alt_data : s_r.mem[rd_idx];
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign rd_q = s_r.q;

endmodule : cmc_rd_store

// ==== sim/cmc_bus_node.sv ====
// Far-side model: a transceiver joined to one other bus node.
// Assumes the bus is wired-AND, recessive high, with no pull of its own.
`timescale 1ns/10ps

module cmc_bus_node (
	// Our transmit pin
	input  wire logic tx,
	// Other node pulls the bus dominant
	input  wire logic force_dom,
	// Level seen back at our receive pin
	output logic      rx
);
	//------------------------------------------------------------
	// Wired-AND bus
	//------------------------------------------------------------
	// Dominant (0) from either side wins over recessive (1)
	assign rx = tx & ~force_dom;
endmodule : cmc_bus_node

// ==== sim/cmc_mode_ctrl_properties.sv ====
// Concurrent checks on the ports of cmc_mode_ctrl.
// Assumes one clock domain with the async active-low reset nrst.
`timescale 1ns/10ps

module cmc_mode_ctrl_checker import cmc_pkg::*; (
	// Clock and reset
	input wire logic          clk,
	input wire logic          nrst,
	// Register port
	input wire logic [7:0]    reg_addr,
	input wire logic [7:0]    reg_wdata,
	input wire logic          reg_wr,
	input wire logic          reg_rd,
	input wire logic [7:0]    reg_rdata,
	// Bus pins and engine
	input wire logic          bus_rx_pin,
	input wire logic          bus_tx_pin,
	input wire cmc_eng_type   eng,
	input wire logic          eng_abort,
	input wire logic          eng_synced,
	input wire logic          eng_sleep,
	input wire logic          mode_loopback,
	input wire logic          mode_listen,
	// Stamp and system
	input wire cmc_stamp_type stamp,
	input wire logic          cpu_wait,
	input wire logic          bus_clk_en
);
	//------------------------------------------------------------
	// Properties
	//------------------------------------------------------------
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!nrst);

	// Clocks run whenever the CPU is not waiting
	property p_clk_gate;
		!cpu_wait |=> bus_clk_en;
	endproperty
	a_clk_gate: assert property (p_clk_gate) else $error("bus clock gated outside wait");

	// High stamp byte follows end of frame, low byte right after
	property p_stamp;
		stamp.we && stamp.off == STAMP_HI |-> $past(eng.eof_ok) ##1 (stamp.we && stamp.off == STAMP_LO);
	endproperty
	a_stamp: assert property (p_stamp) else $error("time stamp write out of order");

	// Sleep is never taken while a frame is arriving
	property p_sleep_idle;
		$rose(eng_sleep) |-> !$past(eng.rx_busy);
	endproperty
	a_sleep_idle: assert property (p_sleep_idle) else $error("sleep entered while receiving");

	// Abort is one cycle and comes with sync lost
	property p_abort;
		$rose(eng_abort) |-> !eng_synced ##1 !eng_abort;
	endproperty
	a_abort: assert property (p_abort) else $error("abort pulse wrong");

	// Mode bits only move while out of normal running
	property p_cfg_lock;
		$changed(mode_listen) || $changed(mode_loopback) |-> !$past(eng_synced);
	endproperty
	a_cfg_lock: assert property (p_cfg_lock) else $error("mode changed while running");

	// Sync is only gained on a bit time
	property p_sync_tick;
		$rose(eng_synced) |-> $past(eng.bit_tick) || $past(eng.bit_tick, 2);
	endproperty
	a_sync_tick: assert property (p_sync_tick) else $error("sync gained off a bit time");

	// Listen-only never drives the bus dominant
	property p_tx_listen;
		mode_listen && $past(mode_listen) |-> bus_tx_pin;
	endproperty
	a_tx_listen: assert property (p_tx_listen) else $error("dominant sent in listen mode");

	// An init request forces the pin recessive
	property p_init_rec;
		reg_wr && reg_addr == OFF_CTL0 && reg_wdata[BIT_INIT_RQ] |-> ##2 bus_tx_pin;
	endproperty
	a_init_rec: assert property (p_init_rec) else $error("pin not recessive on init");
endmodule : cmc_mode_ctrl_checker

bind cmc_mode_ctrl cmc_mode_ctrl_checker u_chk (.clk(clk), .nrst(nrst), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
	.bus_rx_pin(bus_rx_pin), .bus_tx_pin(bus_tx_pin), .eng(eng), .eng_abort(eng_abort),
	.eng_synced(eng_synced), .eng_sleep(eng_sleep), .mode_loopback(mode_loopback),
	.mode_listen(mode_listen), .stamp(stamp), .cpu_wait(cpu_wait), .bus_clk_en(bus_clk_en));

// ==== sim/cmc_mode_ctrl_test.sv ====
// Self-checking bench for cmc_mode_ctrl with a bus node model.
// Assumes a 10 MHz clock; the bench plays CPU and protocol engine.
`timescale 1ns/10ps

module cmc_mode_ctrl_test import cmc_pkg::*;;
	//------------------------------------------------------------
	// Signals
	//------------------------------------------------------------
	logic          clk, nrst, reg_wr, reg_rd, cpu_wait, force_dom;
	logic [7:0]    reg_addr, reg_wdata, reg_rdata;
	logic          bus_rx_pin, bus_tx_pin, eng_abort, eng_synced, eng_sleep;
	logic          mode_loopback, mode_listen, bus_clk_en;
	cmc_eng_type   eng;
	cmc_stamp_type stamp;
	int            num_errors, n_tests, cycles, aborts;

	cmc_mode_ctrl dut (.clk(clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .bus_rx_pin(bus_rx_pin),
		.bus_tx_pin(bus_tx_pin), .eng(eng), .eng_abort(eng_abort), .eng_synced(eng_synced),
		.eng_sleep(eng_sleep), .mode_loopback(mode_loopback), .mode_listen(mode_listen),
		.stamp(stamp), .cpu_wait(cpu_wait), .bus_clk_en(bus_clk_en));
	cmc_bus_node node (.tx(bus_tx_pin), .force_dom(force_dom), .rx(bus_rx_pin));

	//------------------------------------------------------------
	// Clock, timeout, abort counter
	//------------------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	// Whole run is well under a thousand cycles; sampled mid-cycle so flop outputs are settled
	always @(negedge clk) begin
		cycles <= cycles + 1;
		if (eng_abort === 1'b1) aborts <= aborts + 1;
		if (cycles == 3000) begin
			num_errors++;
			print_verdict();
		end
	end

	//------------------------------------------------------------
	// Tasks
	//------------------------------------------------------------
	task print_verdict;
		$display("checks %0d errors %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask : print_verdict
	task chk(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp) begin
			num_errors++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask : chk
	// Waits n edges, then lets that edge's updates land
	task cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : cyc
	task put(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_wr <= w;
		reg_rd <= r;
		reg_addr <= a;
		reg_wdata <= d;
	endtask : put
	task wr(input logic [7:0] a, input logic [7:0] d);
		put(1'b1, 1'b0, a, d);
		put(1'b0, 1'b0, a, d);
	endtask : wr
	// Read data stand only in the cycle after the strobe
	task rd(input logic [7:0] a, input logic [7:0] exp);
		put(1'b0, 1'b1, a, 8'h00);
		put(1'b0, 1'b0, a, 8'h00);
		#1 chk(reg_rdata, exp);
	endtask : rd
	task tick;
		@(posedge clk) eng.bit_tick <= 1'b1;
		@(posedge clk) eng.bit_tick <= 1'b0;
		cyc(3);
	endtask : tick
	// Pulses end of frame and checks both stamp bytes
	task eofchk(input logic [7:0] hi, input logic [7:0] lo);
		@(posedge clk) eng.eof_ok <= 1'b1;
		@(posedge clk) eng.eof_ok <= 1'b0;
		#1 chk({3'h0, stamp.we, stamp.off}, 8'h1E);
		chk(stamp.data, hi);
		cyc(1);
		chk({3'h0, stamp.we, stamp.off}, 8'h1F);
		chk(stamp.data, lo);
	endtask : eofchk

	//------------------------------------------------------------
	// Main sequence
	//------------------------------------------------------------
	initial begin
		nrst = 1'b0;
		{reg_wr, reg_rd, cpu_wait, force_dom, reg_addr, reg_wdata} = '0;
		eng = '0;
		eng.tx_bit = 1'b1;
		cyc(20);
		nrst <= 1'b1;
		rd(OFF_CTL0, 8'h01);
		rd(OFF_CTL1, 8'h11);
		chk({6'h0, mode_loopback, mode_listen}, 8'h01);
		rd(OFF_TFLG, 8'h07);
		rd(8'h0C, 8'h00);
		wr(OFF_CTL0, 8'hAD); rd(OFF_CTL0, 8'h05);
		wr(OFF_CTL1, 8'h80); rd(OFF_CTL1, 8'h81);
		chk({6'h0, mode_loopback, mode_listen}, 8'h00);
		wr(OFF_BT0, 8'h3C); rd(OFF_BT0, 8'h3C);
		// Leave init; software waits for both bits low
		wr(OFF_CTL0, 8'h04); cyc(3); rd(OFF_CTL1, 8'h80);
		wr(OFF_BT0, 8'hFF); rd(OFF_BT0, 8'h3C);
		wr(OFF_CTL0, 8'h7C); rd(OFF_CTL0, 8'h2C);
		// Ten idle bits, one dominant, then eleven idle
		repeat (10) tick();
		@(posedge clk) force_dom <= 1'b1;
		cyc(4); tick();
		@(posedge clk) force_dom <= 1'b0;
		cyc(4);
		repeat (10) tick();
		chk({7'h0, eng_synced}, 8'h00);
		tick();
		chk({7'h0, eng_synced}, 8'h01);
		rd(OFF_CTL0, 8'h3C);
		eofchk(8'h00, 8'h16);
		wr(OFF_CTL0, 8'h24); wr(OFF_CTL0, 8'h2C); eofchk(8'h00, 8'h00);
		@(posedge clk) eng.rx_frame_ok <= 1'b1;
		@(posedge clk) eng.rx_frame_ok <= 1'b0;
		rd(OFF_CTL0, 8'hBC);
		wr(OFF_CTL0, 8'h3C); rd(OFF_CTL0, 8'hBC);
		wr(OFF_CTL0, 8'hBC); rd(OFF_CTL0, 8'h3C);
		// Engine drives dominant; pin must follow in running
		@(posedge clk) eng.tx_bit <= 1'b0;
		cyc(3); chk({7'h0, bus_tx_pin}, 8'h00);
		@(posedge clk) eng.tx_bit <= 1'b1;
		cyc(3); chk({7'h0, bus_tx_pin}, 8'h01);
		@(posedge clk) cpu_wait <= 1'b1;
		cyc(3); chk({7'h0, bus_clk_en}, 8'h00);
		@(posedge clk) cpu_wait <= 1'b0;
		wr(OFF_CTL0, 8'h0C);
		@(posedge clk) cpu_wait <= 1'b1;
		cyc(3); chk({7'h0, bus_clk_en}, 8'h01);
		@(posedge clk) cpu_wait <= 1'b0;
		wr(OFF_CTL0, 8'h2C);
		// Sleep asked while a frame is arriving
		@(posedge clk) eng.rx_busy <= 1'b1;
		rd(OFF_CTL0, 8'h7C);
		wr(OFF_CTL0, 8'h2E); cyc(3); rd(OFF_CTL1, 8'h80);
		@(posedge clk) eng.rx_busy <= 1'b0;
		cyc(3); rd(OFF_CTL1, 8'h82);
		// Other node talks; wake enable ends sleep
		@(posedge clk) force_dom <= 1'b1;
		cyc(6);
		@(posedge clk) force_dom <= 1'b0;
		cyc(4); chk({7'h0, eng_sleep}, 8'h00);
		rd(OFF_CTL0, 8'h2C);
		rd(OFF_RFLG, 8'h80);
		wr(OFF_CTL0, 8'h2E); rd(OFF_CTL0, 8'h2C);
		wr(OFF_RFLG, 8'h80); rd(OFF_RFLG, 8'h00);
		// Init request, then a clear written back to back before its acknowledge; request stays set
		wr(OFF_TIER, 8'h07);
		put(1'b1, 1'b0, OFF_CTL0, 8'h2D);
		put(1'b1, 1'b0, OFF_CTL0, 8'h2C);
		put(1'b0, 1'b0, OFF_CTL0, 8'h2C);
		cyc(3);
		rd(OFF_CTL0, 8'h05);
		rd(OFF_CTL1, 8'h81);
		rd(OFF_TIER, 8'h00);
		chk(aborts[7:0], 8'h01);
		chk({7'h0, bus_tx_pin}, 8'h01);
		print_verdict();
	end
endmodule : cmc_mode_ctrl_test
